//--- bfs_cfg.svh
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH
// ==================================================================
// register offsets
`define BFS_OFS_CTRL     12'h000
`define BFS_OFS_PRESET   12'h004
`define BFS_OFS_REF_PTR  12'h008
`define BFS_OFS_REF_DATA 12'h00C
`define BFS_OFS_MAP      12'h010
`define BFS_OFS_STATUS   12'h014
`define BFS_OFS_CAP      12'h018
// ==================================================================
// field positions
`define BFS_CTRL_DIR_LSB   0
`define BFS_CTRL_SUBST_BIT 2
`define BFS_CTRL_CAPT_BIT  3
`define BFS_CTRL_START_LSB 8
`define BFS_CTRL_LEN_LSB   16
`define BFS_PTR_IDX_LSB    16
`define BFS_MAP_OUT_LSB    16
`define BFS_CMD_BIT        31
// ==================================================================
// values and limits
`define BFS_WIN_MIN        6'h01
`define BFS_WIN_MAX        6'h20
`define BFS_START_RST      6'h01
`define BFS_LEN_RST        6'h20
`define BFS_MISMATCH_CODE  10'h3E7
`define BFS_OUT_MAX        10'h18F
`define BFS_MAX_CHARS      32
`endif

//--- bfs_pkg.sv
package bfs_pkg;
	typedef enum logic [1:0] {
		BFS_DIR_OFF = 2'b00,
		BFS_DIR_FWD = 2'b01,
		BFS_DIR_REV = 2'b10
	} bfs_dir_e;
	typedef enum logic [1:0] {
		BFS_ST_RECV = 2'b00,
		BFS_ST_CALC = 2'b01,
		BFS_ST_EMIT = 2'b10
	} bfs_state_e;
	typedef logic [7:0] bfs_char_t;
	typedef logic [9:0] bfs_word_t;
endpackage

//--- bfs_strm_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bfs_strm_if #(parameter int W = 10);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- bfs_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module bfs_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 8
) (
	input  wire logic   clk,
	input  wire logic   rst_n,
	bfs_strm_if.snk     push,
	bfs_strm_if.src     pop
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("bfs_fifo depth must be a power of two, at least 2");
	end
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	logic         full;
	logic         empty;
	assign empty = (wr_q == rd_q);
	assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign push.ready = !full;
	assign pop.valid = !empty;
	assign pop.data = mem[rd_q[AW-1:0]];
	// ==================================================================
	// pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push.valid && !full) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop.ready && !empty) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
	// ==================================================================
	// storage
	always_ff @(posedge clk) begin
		if (push.valid && !full) begin
			mem[wr_q[AW-1:0]] <= push.data;
		end
	end
endmodule
`default_nettype wire

//--- bfs_outmap.sv
`timescale 1ns/100ps
`default_nettype none
`include "bfs_cfg.svh"
module bfs_outmap #(
	parameter int NUM_PRESETS = 400
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       wr_en,
	input  wire logic [8:0] wr_preset,
	input  wire logic [9:0] wr_output_assignment_menu,
	input  wire logic       defaults,
	input  wire logic [8:0] rd_preset,
	output logic      [9:0] rd_output_assignment_menu,
	input  wire logic [8:0] lk_preset,
	output logic      [9:0] lk_output_assignment_menu
);
	if (NUM_PRESETS < 2 || NUM_PRESETS > 512) begin : g_bad_num
		$error("bfs_outmap preset count out of range");
	end
	logic [9:0] map_q [NUM_PRESETS];
	// ==================================================================
	// table, identity after defaults, preset 0 on mismatch output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_PRESETS; i++) begin
				map_q[i] <= (i == 0) ? `BFS_MISMATCH_CODE : 10'(i);
			end
		end else if (defaults) begin
			for (int i = 0; i < NUM_PRESETS; i++) begin
				map_q[i] <= (i == 0) ? `BFS_MISMATCH_CODE : 10'(i);
			end
		end else if (wr_en && (int'(wr_preset) < NUM_PRESETS)) begin
			map_q[wr_preset] <= wr_output_assignment_menu;
		end
	end
	assign rd_output_assignment_menu = (int'(rd_preset) < NUM_PRESETS) ? map_q[rd_preset] : `BFS_MISMATCH_CODE;
	assign lk_output_assignment_menu = (int'(lk_preset) < NUM_PRESETS) ? map_q[lk_preset] : `BFS_MISMATCH_CODE;
endmodule
`default_nettype wire

//--- bfs_top.sv
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "bfs_cfg.svh"
module bfs_top #(
	parameter int REF_PRESETS = 8,
	parameter int NUM_PRESETS = 400,
	parameter int FIFO_DEPTH  = 8
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          rd_valid,
	output logic               rd_ready,
	input  wire bfs_pkg::bfs_char_t rd_char,
	input  wire logic          rd_last,
	output logic               out_valid,
	input  wire logic          out_ready,
	output bfs_pkg::bfs_char_t out_char,
	output logic               out_last,
	output logic               out_subst,
	output logic               subst_empty,
	input  wire logic          match_valid,
	input  wire logic [8:0]    match_preset,
	output logic               par_valid,
	output logic      [9:0]    par_output_assignment_menu,
	output logic               mismatch_output
);
	import bfs_pkg::*;
	localparam int PW = $clog2(REF_PRESETS);
	if (REF_PRESETS < 2 || (1 << PW) != REF_PRESETS || REF_PRESETS > 400) begin : g_bad_ref
		$error("bfs_top reference preset count must be a power of two, 2 to 256");
	end
	// ==================================================================
	// reset release
	logic [1:0] rst_sync_q;
	logic       rst_n;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];
	// ==================================================================
	// apb slave, one wait state
	logic        wr_en;
	logic        ctrl_wr;
	logic [1:0]  wdir;
	logic [5:0]  wstart;
	logic [5:0]  wlen;
	logic [9:0]  woutno;
	bfs_dir_e    dir_q;
	logic        subst_en_q;
	logic        capt_en_q;
	logic [5:0]  start_q;
	logic [5:0]  len_q;
	logic [8:0]  preset_q;
	logic [PW-1:0] ref_sel_q;
	logic [4:0]  ref_idx_q;
	logic [8:0]  map_sel_q;
	logic [4:0]  cap_idx_q;
	logic [9:0]  map_rd;
	logic [5:0]  kept_q;
	logic [5:0]  cap_len_q;
	bfs_state_e  state_q;
	logic [31:0] rdata;
	logic        hit;
	logic        map_ok;
	logic [7:0]  cap_mem_rd;
	assign wr_en = psel && penable && pwrite && pready;
	assign ctrl_wr = wr_en && (paddr == `BFS_OFS_CTRL);
	assign wdir = pwdata[`BFS_CTRL_DIR_LSB +: 2];
	assign wstart = pwdata[`BFS_CTRL_START_LSB +: 6];
	assign wlen = pwdata[`BFS_CTRL_LEN_LSB +: 6];
	assign woutno = pwdata[`BFS_MAP_OUT_LSB +: 10];
	assign map_ok = (woutno >= 10'h001 && woutno <= `BFS_OUT_MAX) || woutno == `BFS_MISMATCH_CODE;
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr)
			`BFS_OFS_CTRL: begin
				rdata[`BFS_CTRL_DIR_LSB +: 2] = dir_q;
				rdata[`BFS_CTRL_SUBST_BIT] = subst_en_q;
				rdata[`BFS_CTRL_CAPT_BIT] = capt_en_q;
				if (dir_q != BFS_DIR_OFF) begin
					rdata[`BFS_CTRL_START_LSB +: 6] = start_q;
					rdata[`BFS_CTRL_LEN_LSB +: 6] = len_q;
				end
			end
			`BFS_OFS_PRESET: rdata[8:0] = preset_q;
			`BFS_OFS_REF_PTR: begin
				rdata[PW-1:0] = ref_sel_q;
				rdata[`BFS_PTR_IDX_LSB +: 5] = ref_idx_q;
			end
			`BFS_OFS_REF_DATA: rdata = 32'h0000_0000;
			`BFS_OFS_MAP: begin
				rdata[8:0] = map_sel_q;
				rdata[`BFS_MAP_OUT_LSB +: 10] = map_rd;
			end
			`BFS_OFS_STATUS: rdata = {16'h0000, 2'b00, cap_len_q, subst_empty,
				(state_q != BFS_ST_RECV), kept_q};
			`BFS_OFS_CAP: rdata = {11'h000, cap_idx_q, 8'h00, cap_mem_rd};
			default: hit = 1'b0;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready
				&& (!hit || (pwrite && paddr == `BFS_OFS_MAP && !pwdata[`BFS_CMD_BIT] && !map_ok));
			if (psel && penable && !pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rdata;
			end
		end
	end
	// ==================================================================
	// settings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= BFS_DIR_OFF;
			subst_en_q <= 1'b0;
			capt_en_q <= 1'b0;
			start_q <= `BFS_START_RST;
			len_q <= `BFS_LEN_RST;
			preset_q <= 9'h000;
			map_sel_q <= 9'h000;
			cap_idx_q <= 5'h00;
		end else if (wr_en) begin
			if (ctrl_wr) begin
				if (wdir != 2'b11) begin
					dir_q <= bfs_dir_e'(wdir);
				end
				subst_en_q <= pwdata[`BFS_CTRL_SUBST_BIT];
				capt_en_q <= pwdata[`BFS_CTRL_CAPT_BIT];
				if (wdir != 2'b00 && wdir != 2'b11) begin
					if (wstart >= `BFS_WIN_MIN && wstart <= `BFS_WIN_MAX) start_q <= wstart;
					if (wlen >= `BFS_WIN_MIN && wlen <= `BFS_WIN_MAX) len_q <= wlen;
				end
			end
			if (paddr == `BFS_OFS_PRESET) preset_q <= pwdata[8:0];
			if (paddr == `BFS_OFS_MAP) map_sel_q <= pwdata[8:0];
			if (paddr == `BFS_OFS_CAP) cap_idx_q <= pwdata[4:0];
		end
	end
	// ==================================================================
	// substitution strings
	logic [7:0] ref_mem [REF_PRESETS*`BFS_MAX_CHARS];
	logic [5:0] ref_len_q [REF_PRESETS];
	logic       ref_wr;
	assign ref_wr = wr_en && (paddr == `BFS_OFS_REF_DATA);
	always_ff @(posedge clk) begin
		if (ref_wr) begin
			ref_mem[{ref_sel_q, ref_idx_q}] <= pwdata[7:0];
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_sel_q <= '0;
			ref_idx_q <= 5'h00;
			for (int i = 0; i < REF_PRESETS; i++) ref_len_q[i] <= 6'h00;
		end else if (wr_en && paddr == `BFS_OFS_REF_PTR) begin
			ref_sel_q <= pwdata[PW-1:0];
			ref_idx_q <= pwdata[`BFS_PTR_IDX_LSB +: 5];
			if (pwdata[`BFS_CMD_BIT]) ref_len_q[pwdata[PW-1:0]] <= 6'h00;
		end else if (ref_wr) begin
			ref_idx_q <= ref_idx_q + 5'h01;
			if ({1'b0, ref_idx_q} >= ref_len_q[ref_sel_q]) ref_len_q[ref_sel_q] <= {1'b0, ref_idx_q} + 6'h01;
		end
	end
	// ==================================================================
	// readout buffer and window
	logic [7:0] line_mem [`BFS_MAX_CHARS];
	logic [7:0] cap_mem [`BFS_MAX_CHARS];
	logic [5:0] n_q;
	logic [5:0] idx_q;
	logic [5:0] hi_q;
	logic       use_ref_q;
	logic [PW-1:0] rsel_q;
	logic signed [7:0] lo;
	logic signed [7:0] hi;
	logic signed [7:0] nn;
	logic signed [7:0] s;
	logic signed [7:0] l;
	logic       ref_ok;
	logic [5:0] rlen;
	logic       take;
	assign take = rd_valid && rd_ready;
	assign ref_ok = int'(preset_q) < REF_PRESETS;
	assign rlen = ref_ok ? ref_len_q[preset_q[PW-1:0]] : 6'h00;
	assign cap_mem_rd = cap_mem[cap_idx_q];
	always_comb begin
		nn = {2'b00, n_q};
		s = {2'b00, start_q};
		l = {2'b00, len_q};
		case (dir_q)
			BFS_DIR_FWD: begin
				lo = s - 8'sd1;
				hi = s + l - 8'sd2;
				if (hi > nn - 8'sd1) hi = nn - 8'sd1;
			end
			BFS_DIR_REV: begin
				hi = nn - s;
				lo = nn - s - l + 8'sd1;
				if (lo < 8'sd0) lo = 8'sd0;
			end
			default: begin
				lo = 8'sd0;
				hi = nn - 8'sd1;
			end
		endcase
	end
	// ==================================================================
	// frame sequencer
	bfs_strm_if #(.W(10)) push_if ();
	bfs_strm_if #(.W(10)) pop_if ();
	logic [7:0] emit_char;
	logic       emit_go;
	assign emit_char = use_ref_q ? ref_mem[{rsel_q, idx_q[4:0]}] : line_mem[idx_q[4:0]];
	assign push_if.valid = (state_q == BFS_ST_EMIT);
	assign push_if.data = {use_ref_q, idx_q == hi_q, emit_char};
	assign emit_go = push_if.valid && push_if.ready;
	always_ff @(posedge clk) begin
		if (take && !n_q[5]) line_mem[n_q[4:0]] <= rd_char;
		if (emit_go && capt_en_q && !use_ref_q) cap_mem[cap_len_q[4:0]] <= line_mem[idx_q[4:0]];
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= BFS_ST_RECV;
			rd_ready <= 1'b0;
			n_q <= 6'h00;
			idx_q <= 6'h00;
			hi_q <= 6'h00;
			use_ref_q <= 1'b0;
			rsel_q <= '0;
			kept_q <= 6'h00;
			cap_len_q <= 6'h00;
			subst_empty <= 1'b0;
		end else begin
			case (state_q)
				BFS_ST_RECV: begin
					rd_ready <= 1'b1;
					if (take) begin
						if (!n_q[5]) n_q <= n_q + 6'h01;
						if (rd_last) begin
							rd_ready <= 1'b0;
							state_q <= BFS_ST_CALC;
						end
					end
				end
				BFS_ST_CALC: begin
					n_q <= 6'h00;
					state_q <= BFS_ST_RECV;
					subst_empty <= subst_en_q && rlen == 6'h00;
					kept_q <= (hi >= lo && hi >= 8'sd0) ? 6'(hi - lo + 8'sd1) : 6'h00;
					if (capt_en_q) cap_len_q <= 6'h00;
					if (subst_en_q) begin
						use_ref_q <= 1'b1;
						rsel_q <= preset_q[PW-1:0];
						idx_q <= 6'h00;
						hi_q <= rlen - 6'h01;
						if (rlen != 6'h00) state_q <= BFS_ST_EMIT;
					end else begin
						use_ref_q <= 1'b0;
						idx_q <= 6'(lo);
						hi_q <= 6'(hi);
						if (hi >= lo && hi >= 8'sd0) state_q <= BFS_ST_EMIT;
					end
				end
				BFS_ST_EMIT: begin
					if (emit_go) begin
						idx_q <= idx_q + 6'h01;
						if (capt_en_q && !use_ref_q) cap_len_q <= cap_len_q + 6'h01;
						if (idx_q == hi_q) state_q <= BFS_ST_RECV;
					end
				end
				default: state_q <= BFS_ST_RECV;
			endcase
		end
	end
	bfs_fifo #(.W(10), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.push  (push_if),
		.pop   (pop_if)
	);
	// ==================================================================
	// output stage
	assign pop_if.ready = !out_valid || out_ready;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_char <= 8'h00;
			out_last <= 1'b0;
			out_subst <= 1'b0;
		end else if (pop_if.ready) begin
			out_valid <= pop_if.valid;
			if (pop_if.valid) begin
				{out_subst, out_last, out_char} <= pop_if.data;
			end
		end
	end
	// ==================================================================
	// output mapping
	logic [9:0] lk;
	bfs_outmap #(.NUM_PRESETS(NUM_PRESETS)) u_map (
		.clk       (clk),
		.rst_n     (rst_n),
		.wr_en     (wr_en && paddr == `BFS_OFS_MAP && !pwdata[`BFS_CMD_BIT] && map_ok),
		.wr_preset (pwdata[8:0]),
		.wr_output_assignment_menu  (woutno),
		.defaults  (wr_en && paddr == `BFS_OFS_MAP && pwdata[`BFS_CMD_BIT]),
		.rd_preset (map_sel_q),
		.rd_output_assignment_menu  (map_rd),
		.lk_preset (match_preset),
		.lk_output_assignment_menu  (lk)
	);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			par_valid <= 1'b0;
			par_output_assignment_menu <= 10'h000;
			mismatch_output <= 1'b0;
		end else begin
			par_valid <= match_valid;
			if (match_valid) begin
				mismatch_output <= (lk == `BFS_MISMATCH_CODE);
				par_output_assignment_menu <= (lk == `BFS_MISMATCH_CODE) ? 10'h000 : lk;
			end
		end
	end
endmodule
`default_nettype wire

//--- bfs_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// port checker
module bfs_top_asserts #(
	parameter int NUM_PRESETS = 400
) (
	input wire logic               clk,
	input wire logic               rstn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               rd_valid,
	input wire logic               rd_ready,
	input wire logic               rd_last,
	input wire logic               out_valid,
	input wire logic               out_ready,
	input wire bfs_pkg::bfs_char_t out_char,
	input wire logic               out_last,
	input wire logic               out_subst,
	input wire logic               match_valid,
	input wire logic               par_valid,
	input wire logic      [9:0]    par_output_assignment_menu,
	input wire logic               mismatch_output
);
	import bfs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_par_after_match: assert property (match_valid |=> par_valid)
		else $error("par_valid missing after match_valid");
	a_no_par_idle: assert property (!match_valid |=> !par_valid)
		else $error("par_valid without match_valid");
	a_mismatch_zero: assert property (par_valid && mismatch_output |-> par_output_assignment_menu == 10'h000)
		else $error("mismatch output with nonzero output number");
	a_output_assignment_menu_range: assert property (par_valid && !mismatch_output |-> par_output_assignment_menu inside {[1:NUM_PRESETS-1]})
		else $error("output number out of range");
	a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_char) && $stable(out_last))
		else $error("output char changed while stalled");
	a_pready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_slverr_pready: assert property (pslverr |-> pready && $past(psel && penable))
		else $error("pslverr outside answer");
	a_rd_stop_last: assert property (rd_valid && rd_ready && rd_last |=> !rd_ready)
		else $error("rd_ready high after last char");
	c_frame_end: cover property (out_valid && out_ready && out_last && out_subst);
	c_par_mismatch: cover property (par_valid && mismatch_output);
	c_apb_error: cover property (pslverr && pready);
endmodule
bind bfs_top bfs_top_asserts #(.NUM_PRESETS(NUM_PRESETS)) i_chk (.clk, .rstn, .psel, .penable, .pready, .pslverr,
	.rd_valid, .rd_ready, .rd_last, .out_valid, .out_ready, .out_char, .out_last, .out_subst, .match_valid,
	.par_valid, .par_output_assignment_menu, .mismatch_output);
`default_nettype wire

//--- bfs_reader_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// readout source
module bfs_reader_model (
	input  wire logic              clk,
	input  wire logic              rd_ready,
	output var logic               rd_valid,
	output var bfs_pkg::bfs_char_t rd_char,
	output var logic               rd_last
);
	import bfs_pkg::*;
	initial begin
		rd_valid = 1'b0;
		rd_char = 8'hA5;
		rd_last = 1'b0;
	end
	// one readout; gap idle cycles between chars, released char shows inverted
	task automatic send(input string s, input int gap);
		for (int i = 0; i < s.len(); i++) begin
			rd_valid <= 1'b1;
			rd_char <= s[i];
			rd_last <= (i == s.len() - 1);
			do @(posedge clk); while (rd_ready !== 1'b1);
			if (gap > 0 || i == s.len() - 1) begin
				rd_valid <= 1'b0;
				rd_last <= 1'b0;
				rd_char <= ~s[i];
				repeat (gap) @(posedge clk);
			end
		end
	endtask
endmodule
`default_nettype wire

//--- bfs_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "bfs_cfg.svh"
// ==================================================================
// testbench
module bfs_top_tb_top;
	import bfs_pkg::*;
	logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rd_valid, rd_ready, rd_last;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic        out_valid, out_ready = 0, out_last, out_subst, subst_empty, match_valid = 0, par_valid;
	logic        mismatch_output, rerr, got_sub, got_lst;
	logic [8:0]  match_preset = 0;
	logic [9:0]  par_output_assignment_menu;
	bfs_char_t   rd_char, out_char;
	logic [255:0] got_f;
	int          n_mismatch = 0, n_compared = 0, cyc = 0, got_n = 0, n;
	int          tp[6] = '{3, 4, 399, 1, 6, 6};
	int          to[6] = '{5, 5, 999, 999, 400, 399};
	bfs_top #(.REF_PRESETS(8), .NUM_PRESETS(400), .FIFO_DEPTH(8)) i_dut (.clk, .rstn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rd_valid, .rd_ready, .rd_char, .rd_last, .out_valid,
		.out_ready, .out_char, .out_last, .out_subst, .subst_empty, .match_valid, .match_preset, .par_valid,
		.par_output_assignment_menu, .mismatch_output);
	bfs_reader_model i_rdr (.clk, .rd_ready, .rd_valid, .rd_char, .rd_last);
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		out_ready <= cyc[1];
		if (out_valid && out_ready) begin
			got_f <= {got_f[247:0], out_char};
			got_n <= got_n + 1;
			got_sub <= out_subst;
			got_lst <= out_last;
		end
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_f(input string nm, input logic [255:0] e, input logic [255:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %0s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	function automatic logic [31:0] ctl(input logic [3:0] f, input int st, input int ln);
		return {10'h0, 6'(ln), 2'h0, 6'(st), 4'h0, f};
	endfunction
	function automatic logic [31:0] mw(input int p, input int o);
		return {6'h0, 10'(o), 7'h0, 9'(p)};
	endfunction
	function automatic logic [255:0] pk(input string s);
		pk = '0;
		for (int i = 0; i < s.len(); i++)
			pk = {pk[247:0], s[i]};
	endfunction
	task automatic frm(input string nm, input logic [31:0] c, input string s, input string e, input int gap);
		int k;
		got_f <= '0;
		got_n <= 0;
		wr(`BFS_OFS_CTRL, c);
		i_rdr.send(s, gap);
		k = 0;
		while (got_n != e.len() && k < 200) begin
			@(posedge clk);
			k++;
		end
		do rd(`BFS_OFS_STATUS); while (rdat[6] !== 1'b0 && k++ < 250);
		chk_w(nm, 32'(e.len()), {26'h0, rdat[5:0]});
		chk_f(nm, pk(e), got_f);
		if (e.len() > 0) chk_w({nm, "_last"}, 32'h1, {31'h0, got_lst});
		$display("test %0s done", nm);
	endtask
	task automatic mt(input int p, input logic [11:0] e);
		match_valid <= 1'b1;
		match_preset <= 9'(p);
		@(posedge clk);
		match_valid <= 1'b0;
		@(negedge clk);
		chk_w("map", {20'h0, e}, {20'h0, par_valid, mismatch_output, par_output_assignment_menu});
		@(posedge clk);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`BFS_OFS_CTRL);
		chk_w("ctrl_rst", 32'h0, rdat);
		wr(`BFS_OFS_CTRL, ctl(4'h0, 5, 3));
		rd(`BFS_OFS_CTRL);
		chk_w("ctrl_off", 32'h0, rdat);
		wr(`BFS_OFS_CTRL, ctl(4'h1, 0, 0));
		rd(`BFS_OFS_CTRL);
		chk_w("ctrl_fwd", 32'h0020_0101, rdat);
		rd(12'h01C);
		chk_w("unmapped", 32'h1, {31'h0, rerr});
		$display("test registers done");
		frm("fwd", ctl(4'h1, 5, 3), "49123456", "345", 0);
		frm("rev", ctl(4'h2, 3, 2), "158423421", "34", 2);
		frm("fwd_clip", ctl(4'h1, 7, 5), "49123456", "56", 1);
		frm("rev_clip", ctl(4'h2, 7, 5), "49123456", "49", 0);
		frm("rev_max", ctl(4'h2, 1, 32), "49123456", "49123456", 0);
		frm("fwd_last", ctl(4'h1, 8, 1), "49123456", "6", 0);
		frm("off", ctl(4'h0, 0, 0), "4912", "4912", 0);
		frm("empty", ctl(4'h1, 20, 3), "49123456", "", 0);
		frm("capture", ctl(4'h9, 5, 3), "49123456", "345", 0);
		chk_w("raw_mark", 32'h0, {31'h0, got_sub});
		rd(`BFS_OFS_STATUS);
		chk_w("cap_len", 32'h3, {26'h0, rdat[13:8]});
		wr(`BFS_OFS_CAP, 32'h1);
		rd(`BFS_OFS_CAP);
		chk_w("cap_char", 32'h0001_0034, rdat);
		wr(`BFS_OFS_REF_PTR, 32'h8000_0002);
		wr(`BFS_OFS_REF_PTR, 32'h2);
		wr(`BFS_OFS_REF_DATA, 32'h41);
		wr(`BFS_OFS_REF_DATA, 32'h42);
		wr(`BFS_OFS_REF_PTR, 32'h8000_0005);
		wr(`BFS_OFS_REF_PTR, 32'h5);
		wr(`BFS_OFS_REF_DATA, 32'h51);
		wr(`BFS_OFS_PRESET, 32'h2);
		frm("subst", ctl(4'h5, 1, 2), "XYZ", "AB", 0);
		chk_w("subst_mark", 32'h1, {31'h0, got_sub});
		chk_w("subst_full", 32'h0, {31'h0, subst_empty});
		wr(`BFS_OFS_PRESET, 32'h5);
		frm("subst_sel", ctl(4'h5, 1, 1), "XYZ", "Q", 0);
		wr(`BFS_OFS_PRESET, 32'h3);
		i_rdr.send("XYZ", 0);
		n = 0;
		while (subst_empty !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		rd(`BFS_OFS_STATUS);
		chk_w("subst_none", 32'h1, {31'h0, rdat[7]});
		wr(`BFS_OFS_MAP, 32'h8000_0000);
		mt(7, {2'b10, 10'd7});
		mt(0, {2'b11, 10'd0});
		for (int i = 0; i < 6; i++) begin
			wr(`BFS_OFS_MAP, mw(tp[i], to[i]));
			n = !((to[i] >= 1 && to[i] <= 399) || to[i] == 999);
			chk_w("map_err", 32'(n), {31'h0, rerr});
			n = n ? tp[i] : to[i];
			mt(tp[i], (n == 999) ? 12'hC00 : {2'b10, 10'(n)});
		end
		rd(`BFS_OFS_MAP);
		chk_w("map_rd", mw(6, 399), rdat);
		$display("test mapping done");
		complete_run();
	end
endmodule
`default_nettype wire
